// *** bench/dfs_host_model.sv ***
// Host side APB master that runs one transfer at a time for the bench.
// Assumes transfers are started from the bench's main sequence on pclk.
`timescale 1ns/10ps
module dfs_host_model (
   // Clock
   input wire logic pclk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic timed_out;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      timed_out = 1'b0;
   end

   // ------------------------------------------------------------
   // One transfer: setup, then access held until pready
   // ------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      timed_out = (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines toggle so nothing can lean on a stale address or data
      paddr <= ~addr;
      pwdata <= ~wdata;
   endtask
endmodule

// *** bench/test_dfs_status_bank.sv ***
// Self-checking bench for the status readback bank.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/10ps
`define CHECK(got, want) begin total_checks++; if ((got) !== (want)) begin fails++; \
   $display("[FAIL] %0t got %h want %h", $time, got, want); end end
module test_dfs_status_bank
   import dfs_status_pkg::*;
;
   // Arbitrary identification value for this run
   localparam logic [7:0] ID_CODE = 8'h3c;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [19:0] nom, tuned_freq;
   dfs_status_type st;
   dfs_event_type ev;
   int fails = 0;
   int total_checks = 0;

   dfs_status_bank #(.ADDR_WIDTH(8), .DEVICE_ID(ID_CODE)) u_dfs_status_bank (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .status(st), .events(ev), .nominal_start_freq(nom), .tuned_freq(tuned_freq));
   dfs_host_model u_dfs_host_model (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic complete_run;
      if (fails == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      u_dfs_host_model.xfer(w, a, 32'hdeadbeef, rdata, err);
      if (u_dfs_host_model.timed_out) begin
         fails++;
         complete_run;
      end
      if (!w)
         `CHECK(rdata, d)
      `CHECK(err, e)
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic reg_map;
      bus(1'b0, 8'h00, 32'h2b, 1'b0);
      bus(1'b0, 8'h04, 32'hab, 1'b0);
      bus(1'b0, 8'h08, 32'hcd, 1'b0);
      bus(1'b0, 8'h0c, 32'he0, 1'b0);
      bus(1'b0, 8'h10, 32'h13, 1'b0);
      bus(1'b0, 8'h14, 32'h57, 1'b0);
      bus(1'b0, 8'h18, 32'h90, 1'b0);
      bus(1'b0, 8'h1c, 32'h01, 1'b0);
      bus(1'b0, 8'h20, 32'hc3, 1'b0);
      bus(1'b0, 8'h24, 32'h84, 1'b0);
      bus(1'b0, 8'h28, 32'h21, 1'b0);
      // Noise measure is read while the phase lock flag is still set
      bus(1'b0, 8'h34, 32'h6e, 1'b0);
      bus(1'b0, 8'h38, 32'hf0, 1'b0);
      bus(1'b0, 8'h3c, 32'h0d, 1'b0);
      bus(1'b0, 8'h58, 32'h12, 1'b0);
      bus(1'b0, 8'h5c, 32'h34, 1'b0);
      bus(1'b0, 8'h60, 32'h56, 1'b0);
      bus(1'b0, 8'h7c, {24'h0, ID_CODE}, 1'b0);
      st.phase_lock <= 1'b0;
      bus(1'b0, 8'h1c, 32'h00, 1'b0);
      for (int i = 0; i < 5; i++) begin
         st.code_rate <= 3'(i);
         bus(1'b0, 8'h64, 32'(i), 1'b0);
         {st.pi2_resolved, st.pi_resolved, st.byte_sync, st.frame_sync, st.node_sync}
            <= 5'(1 << i);
         bus(1'b0, 8'h6c, 32'(1 << i), 1'b0);
      end
   endtask

   task automatic baseband;
      @(posedge pclk);
      ev.inphase <= 8'h81;
      ev.quadrature <= 8'h7e;
      ev.symbol_tick <= 1'b1;
      @(posedge pclk);
      ev <= '0;
      bus(1'b0, 8'h2c, 32'h81, 1'b0);
      bus(1'b0, 8'h30, 32'h7e, 1'b0);
      // Sample moves without a tick, so the held value must not follow it
      ev.inphase <= 8'h11;
      bus(1'b0, 8'h2c, 32'h81, 1'b0);
   endtask

   task automatic block_counters;
      for (int i = 0; i < 255; i++) begin
         @(posedge pclk);
         ev.uncorrectable <= 1'b1;
         ev.block_done <= (i < 2);
         ev.block_errors <= (i == 0) ? 4'h5 : 4'h8;
      end
      @(posedge pclk);
      ev <= '0;
      bus(1'b0, 8'h68, 32'h08, 1'b0);
      bus(1'b0, 8'h70, 32'h00, 1'b0);
      bus(1'b0, 8'h74, 32'h0d, 1'b0);
      bus(1'b0, 8'h74, 32'h0d, 1'b0);
      bus(1'b0, 8'h78, 32'hff, 1'b0);
      ev.uncorrectable <= 1'b1;
      repeat (2) @(posedge pclk);
      ev.uncorrectable <= 1'b0;
      bus(1'b0, 8'h78, 32'h01, 1'b0);
   endtask

   task automatic clear_refuse;
      bus(1'b1, 8'h00, 32'h0, 1'b1);
      bus(1'b0, 8'h74, 32'h0d, 1'b0);
      bus(1'b0, 8'h44, 32'h0, 1'b1);
      bus(1'b0, 8'h80, 32'h0, 1'b1);
      // A word lost in the clearing cycle still counts once after the clear
      ev.uncorrectable <= 1'b1;
      bus(1'b1, 8'h40, 32'h0, 1'b0);
      ev.uncorrectable <= 1'b0;
      bus(1'b0, 8'h70, 32'h00, 1'b0);
      bus(1'b0, 8'h74, 32'h00, 1'b0);
      bus(1'b0, 8'h78, 32'h01, 1'b0);
      bus(1'b1, 8'h40, 32'h0, 1'b0);
      bus(1'b0, 8'h78, 32'h00, 1'b0);
   endtask

   task automatic tuned;
      @(posedge pclk);
      nom <= 20'hfedcb;
      repeat (3) @(posedge pclk);
      `CHECK(tuned_freq, 20'(st.carrier_freq + {4'h0, st.sweep_freq} + nom))
   endtask

   // ------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      nom = 20'h0;
      ev = '0;
      st = '0;
      st.narrowband_gain = 6'h2b;
      st.symbol_freq = 20'habcde;
      st.carrier_freq = 20'h13579;
      st.phase_lock = 1'b1;
      st.wideband_gain = 8'hc3;
      st.sweep_freq = 16'h8421;
      st.noise_power = 8'h6e;
      st.bit_errors = 16'hf00d;
      st.signal_quality = 24'h123456;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      reg_map;
      baseband;
      block_counters;
      clear_refuse;
      tuned;
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      complete_run;
   end
endmodule

// *** verilog/dfs_status_bank.sv ***
// Status and monitor bank of the demodulator and decoder, on APB; read-only apart from the counter clear.
// Assumes status levels and event pulses synchronous to pclk.
`timescale 1ns/10ps
`include "dfs_status_params.svh"

module dfs_status_bank
   import dfs_status_pkg::*;
#(
   parameter int ADDR_WIDTH = 8,
   // Arbitrary identification value
   parameter logic [7:0] DEVICE_ID = 8'h5a
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receiver status and events
   input wire dfs_status_type status,
   input wire dfs_event_type events,
   input wire logic [19:0] nominal_start_freq,
   // Derived results
   output logic [19:0] tuned_freq
);

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire logic [4:0] reg_index;
   wire logic addr_in_range;
   wire logic index_mapped;
   wire logic access_wait;
   wire logic access_done;
   wire logic clear_strobe;
   wire logic [7:0] read_value;
   wire logic next_pslverr;

   assign reg_index = paddr[`DFS_ADDR_IDX_MSB:`DFS_ADDR_IDX_LSB];
   // Any address bit outside the index field must be zero
   assign addr_in_range = (paddr[1:0] == 2'h0) &&
                          ((paddr >> (`DFS_ADDR_IDX_MSB + 1)) == '0);
   assign index_mapped = addr_in_range &&
                         !((reg_index >= `DFS_IDX_COUNTER_CLEAR) &&
                           (reg_index <= `DFS_IDX_GAP_LAST));
   assign access_wait = psel && penable && !pready;
   assign access_done = psel && penable && pready;
   // Whatever value is written, the strobe fires at the completing edge
   assign clear_strobe = access_done && pwrite && addr_in_range &&
                         (reg_index == `DFS_IDX_COUNTER_CLEAR);
   // Writes to read-only locations and unmapped reads are refused
   assign next_pslverr = pwrite ?
                         !(addr_in_range && (reg_index == `DFS_IDX_COUNTER_CLEAR)) :
                         !index_mapped;

   // ----------------------------------------------------------------------
   // Captured values and counters
   // ----------------------------------------------------------------------
   logic [7:0] inphase;
   logic [7:0] quadrature;
   logic [3:0] block_errors;
   logic [15:0] total_errors;
   logic [7:0] uncorr_count;
   wire logic [15:0] next_total_errors;
   wire logic [7:0] next_uncorr_count;
   wire logic [15:0] block_add;
   wire logic [7:0] uncorr_add;

   assign block_add = events.block_done ? {12'h000, events.block_errors} : 16'h0000;
   assign uncorr_add = events.uncorrectable ? 8'h01 : 8'h00;
   // A block finishing in the clearing cycle is counted, not lost
   assign next_total_errors = clear_strobe ? block_add :
                              16'(total_errors + block_add);
   // Eight-bit sum rolls from the maximum back to zero
   assign next_uncorr_count = clear_strobe ? uncorr_add :
                              8'(uncorr_count + uncorr_add);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inphase <= `DFS_RST_BYTE;
         quadrature <= `DFS_RST_BYTE;
      end else if (events.symbol_tick) begin
         inphase <= events.inphase;
         quadrature <= events.quadrature;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_errors <= `DFS_RST_NIBBLE;
      end else if (events.block_done) begin
         block_errors <= events.block_errors;
      end
   end

   // Counters move only on events and the clear; reads never touch them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         total_errors <= `DFS_RST_TOTAL;
         uncorr_count <= `DFS_RST_BYTE;
      end else begin
         total_errors <= next_total_errors;
         uncorr_count <= next_uncorr_count;
      end
   end

   // Sum is kept modulo the accumulator width; the sweep sits at the low end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tuned_freq <= `DFS_RST_TUNED;
      end else begin
         tuned_freq <= 20'(status.carrier_freq + {4'h0, status.sweep_freq} +
                           nominal_start_freq);
      end
   end

   // ----------------------------------------------------------------------
   // Read selection
   // ----------------------------------------------------------------------
   function automatic logic [7:0] select_byte(input logic [4:0] index);
      logic [7:0] value;
      value = 8'h00;
      unique case (index)
         `DFS_IDX_NARROWBAND_GAIN: value = {2'h0, status.narrowband_gain};
         `DFS_IDX_SYMBOL_FREQ_HI: value = status.symbol_freq[19:12];
         `DFS_IDX_SYMBOL_FREQ_MID: value = status.symbol_freq[11:4];
         `DFS_IDX_SYMBOL_FREQ_LO: value = {status.symbol_freq[3:0], 4'h0};
         `DFS_IDX_CARRIER_FREQ_HI: value = status.carrier_freq[19:12];
         `DFS_IDX_CARRIER_FREQ_MID: value = status.carrier_freq[11:4];
         `DFS_IDX_CARRIER_FREQ_LO: value = {status.carrier_freq[3:0], 4'h0};
         `DFS_IDX_PHASE_LOCK: value = {7'h00, status.phase_lock};
         // Meaningful only while the wideband loop runs in its first mode
         `DFS_IDX_WIDEBAND_GAIN: value = status.wideband_gain;
         `DFS_IDX_SWEEP_HI: value = status.sweep_freq[15:8];
         `DFS_IDX_SWEEP_LO: value = status.sweep_freq[7:0];
         `DFS_IDX_INPHASE: value = inphase;
         `DFS_IDX_QUADRATURE: value = quadrature;
         // Trustworthy only after phase lock; quieter with gain loop paused
         `DFS_IDX_NOISE: value = status.noise_power;
         `DFS_IDX_BIT_ERR_HI: value = status.bit_errors[15:8];
         `DFS_IDX_BIT_ERR_LO: value = status.bit_errors[7:0];
         `DFS_IDX_QUALITY_HI: value = status.signal_quality[23:16];
         `DFS_IDX_QUALITY_MID: value = status.signal_quality[15:8];
         `DFS_IDX_QUALITY_LO: value = status.signal_quality[7:0];
         `DFS_IDX_CODE_RATE: value = {5'h00, status.code_rate};
         `DFS_IDX_BLOCK_ERR: value = {4'h0, block_errors};
         `DFS_IDX_SYNC_FLAGS: value = {3'h0, status.pi2_resolved,
                                      status.pi_resolved,
                                      status.byte_sync, status.frame_sync,
                                      status.node_sync};
         `DFS_IDX_TOTAL_ERR_HI: value = total_errors[15:8];
         `DFS_IDX_TOTAL_ERR_LO: value = total_errors[7:0];
         `DFS_IDX_UNCORR: value = uncorr_count;
         `DFS_IDX_DEVICE_ID: value = DEVICE_ID;
         default: value = 8'h00;
      endcase
      return value;
   endfunction

   assign read_value = index_mapped ? select_byte(reg_index) : 8'h00;

   // ----------------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------------
   // One wait state keeps every bus output a flop, at the cost of latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `DFS_RST_WORD;
      end else begin
         pready <= access_wait;
         pslverr <= access_wait && next_pslverr;
         if (access_wait && !pwrite) begin
            prdata <= {24'h000000, read_value};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence wait_phase_s;
      psel && penable && !pready;
   endsequence

   sequence read_done_s;
      psel && penable && pready && !pwrite;
   endsequence

   ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
      wait_phase_s |=> pready ##1 !pready)
      else $error("pready not a single pulse one cycle after access");

   clear_total_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clear_strobe && !events.block_done) |=> (total_errors == 16'h0000))
      else $error("corrected count not cleared by write");

   clear_keeps_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clear_strobe && events.uncorrectable) |=> (uncorr_count == 8'h01))
      else $error("uncorrectable event lost during clear");

   uncorr_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (uncorr_count == `DFS_UNCORR_MAX && events.uncorrectable && !clear_strobe)
      |=> (uncorr_count == 8'h00))
      else $error("uncorrectable count did not wrap");

   total_accum_a: assert property (@(posedge pclk) disable iff (!presetn)
      (events.block_done && !clear_strobe) |=>
      (total_errors == 16'($past(total_errors) + {12'h000, $past(events.block_errors)})))
      else $error("corrected count did not accumulate block");

   read_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      (read_done_s and (!events.block_done && !events.uncorrectable))
      |=> ($stable(total_errors) && $stable(uncorr_count)))
      else $error("read disturbed a counter");

   symbol_refresh_a: assert property (@(posedge pclk) disable iff (!presetn)
      events.symbol_tick |=> (inphase == $past(events.inphase)) &&
                             (quadrature == $past(events.quadrature)))
      else $error("filter outputs not refreshed on symbol");

   lock_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (read_done_s and ($past(reg_index) == `DFS_IDX_PHASE_LOCK) and $past(addr_in_range))
      |-> (prdata == {31'h00000000, $past(status.phase_lock)}))
      else $error("lock flag read wrong");

   id_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (read_done_s and ($past(reg_index) == `DFS_IDX_DEVICE_ID) and $past(addr_in_range))
      |-> (prdata == {24'h000000, DEVICE_ID}) && !pslverr)
      else $error("identifier read wrong");

   gap_error_a: assert property (@(posedge pclk) disable iff (!presetn)
      (read_done_s and $past(!index_mapped)) |-> pslverr && (prdata == 32'h00000000))
      else $error("unmapped read not refused");

   // ----------------------------------------------------------------------
   // Read map checks
   // ----------------------------------------------------------------------
   // A completed read whose access phase addressed the given index; the byte
   // was sampled one edge earlier, so the expected fields are taken from there
   sequence read_of_s(logic [4:0] idx);
      read_done_s ##0 ($past(reg_index) == idx) ##0 $past(addr_in_range);
   endsequence

   upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_done_s |-> (prdata[31:8] == 24'h000000))
      else $error("reserved read data bits not zero");

   gain_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_NARROWBAND_GAIN) |->
      (prdata[7:0] == {2'h0, $past(status.narrowband_gain)}))
      else $error("narrowband gain read wrong");

   symbol_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_SYMBOL_FREQ_HI) |-> (prdata[7:0] == $past(status.symbol_freq[19:12])))
      else $error("symbol accumulator high byte wrong");

   symbol_mid_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_SYMBOL_FREQ_MID) |-> (prdata[7:0] == $past(status.symbol_freq[11:4])))
      else $error("symbol accumulator middle byte wrong");

   symbol_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_SYMBOL_FREQ_LO) |->
      (prdata[7:0] == {$past(status.symbol_freq[3:0]), 4'h0}))
      else $error("symbol accumulator low bits wrong");

   carrier_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_CARRIER_FREQ_HI) |-> (prdata[7:0] == $past(status.carrier_freq[19:12])))
      else $error("carrier accumulator high byte wrong");

   carrier_mid_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_CARRIER_FREQ_MID) |-> (prdata[7:0] == $past(status.carrier_freq[11:4])))
      else $error("carrier accumulator middle byte wrong");

   carrier_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_CARRIER_FREQ_LO) |->
      (prdata[7:0] == {$past(status.carrier_freq[3:0]), 4'h0}))
      else $error("carrier accumulator low bits wrong");

   wideband_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_WIDEBAND_GAIN) |-> (prdata[7:0] == $past(status.wideband_gain)))
      else $error("wideband gain read wrong");

   sweep_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_SWEEP_HI) |-> (prdata[7:0] == $past(status.sweep_freq[15:8])))
      else $error("sweep high byte wrong");

   sweep_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_SWEEP_LO) |-> (prdata[7:0] == $past(status.sweep_freq[7:0])))
      else $error("sweep low byte wrong");

   inphase_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_INPHASE) |-> (prdata[7:0] == $past(inphase)))
      else $error("in-phase filter read wrong");

   quad_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_QUADRATURE) |-> (prdata[7:0] == $past(quadrature)))
      else $error("quadrature filter read wrong");

   noise_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_NOISE) |-> (prdata[7:0] == $past(status.noise_power)))
      else $error("noise power read wrong");

   ber_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_BIT_ERR_HI) |-> (prdata[7:0] == $past(status.bit_errors[15:8])))
      else $error("bit error count high byte wrong");

   ber_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_BIT_ERR_LO) |-> (prdata[7:0] == $past(status.bit_errors[7:0])))
      else $error("bit error count low byte wrong");

   quality_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_QUALITY_HI) |-> (prdata[7:0] == $past(status.signal_quality[23:16])))
      else $error("signal quality high byte wrong");

   quality_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_QUALITY_LO) |-> (prdata[7:0] == $past(status.signal_quality[7:0])))
      else $error("signal quality low byte wrong");

   rate_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_CODE_RATE) |-> (prdata[7:0] == {5'h00, $past(status.code_rate)}))
      else $error("code rate read wrong");

   block_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_BLOCK_ERR) |-> (prdata[7:0] == {4'h0, $past(block_errors)}))
      else $error("block corrections read wrong");

   sync_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_SYNC_FLAGS) |-> (prdata[2:0] == {$past(status.byte_sync),
      $past(status.frame_sync), $past(status.node_sync)}))
      else $error("sync flags read wrong");

   ambiguity_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_SYNC_FLAGS) |->
      (prdata[4:3] == {$past(status.pi2_resolved), $past(status.pi_resolved)}))
      else $error("ambiguity flags read wrong");

   total_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_TOTAL_ERR_HI) |-> (prdata[7:0] == $past(total_errors[15:8])))
      else $error("corrected count high byte wrong");

   total_lo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_TOTAL_ERR_LO) |-> (prdata[7:0] == $past(total_errors[7:0])))
      else $error("corrected count low byte wrong");

   uncorr_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      read_of_s(`DFS_IDX_UNCORR) |-> (prdata[7:0] == $past(uncorr_count)))
      else $error("uncorrectable count read wrong");

   // ----------------------------------------------------------------------
   // Write and derived checks
   // ----------------------------------------------------------------------
   tuned_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (tuned_freq == 20'($past(status.carrier_freq) +
      {4'h0, $past(status.sweep_freq)} + $past(nominal_start_freq))))
      else $error("tuned frequency not the three-term sum");

   clear_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
      clear_strobe |-> (pready && !pslverr))
      else $error("counter clear write refused");

   write_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
      (access_done && pwrite && !clear_strobe) |-> pslverr)
      else $error("write to read-only location accepted");

endmodule

// *** verilog/dfs_status_params.svh ***
// Offsets, field positions, reset values and the uncorrectable count maximum of the status readback bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef DFS_STATUS_PARAMS_SVH
`define DFS_STATUS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DFS_IDX_NARROWBAND_GAIN 5'h00
`define DFS_IDX_SYMBOL_FREQ_HI 5'h01
`define DFS_IDX_SYMBOL_FREQ_MID 5'h02
`define DFS_IDX_SYMBOL_FREQ_LO 5'h03
`define DFS_IDX_CARRIER_FREQ_HI 5'h04
`define DFS_IDX_CARRIER_FREQ_MID 5'h05
`define DFS_IDX_CARRIER_FREQ_LO 5'h06
`define DFS_IDX_PHASE_LOCK 5'h07
`define DFS_IDX_WIDEBAND_GAIN 5'h08
`define DFS_IDX_SWEEP_HI 5'h09
`define DFS_IDX_SWEEP_LO 5'h0a
`define DFS_IDX_INPHASE 5'h0b
`define DFS_IDX_QUADRATURE 5'h0c
`define DFS_IDX_NOISE 5'h0d
`define DFS_IDX_BIT_ERR_HI 5'h0e
`define DFS_IDX_BIT_ERR_LO 5'h0f
`define DFS_IDX_COUNTER_CLEAR 5'h10
`define DFS_IDX_GAP_LAST 5'h15
`define DFS_IDX_QUALITY_HI 5'h16
`define DFS_IDX_QUALITY_MID 5'h17
`define DFS_IDX_QUALITY_LO 5'h18
`define DFS_IDX_CODE_RATE 5'h19
`define DFS_IDX_BLOCK_ERR 5'h1a
`define DFS_IDX_SYNC_FLAGS 5'h1b
`define DFS_IDX_TOTAL_ERR_HI 5'h1c
`define DFS_IDX_TOTAL_ERR_LO 5'h1d
`define DFS_IDX_UNCORR 5'h1e
`define DFS_IDX_DEVICE_ID 5'h1f

// ----------------------------------------------------------------------
// Address field positions
// ----------------------------------------------------------------------
`define DFS_ADDR_IDX_MSB 6
`define DFS_ADDR_IDX_LSB 2

// ----------------------------------------------------------------------
// Reset values and the uncorrectable count maximum
// ----------------------------------------------------------------------
`define DFS_RST_BYTE 8'h00
`define DFS_RST_NIBBLE 4'h0
`define DFS_RST_TOTAL 16'h0000
`define DFS_RST_TUNED 20'h00000
`define DFS_RST_WORD 32'h00000000
`define DFS_UNCORR_MAX 8'hff

`endif

// *** verilog/dfs_status_pkg.sv ***
// Types shared by the status readback bank and its surroundings.
// Assumes the params header is on the include path.
package dfs_status_pkg;
`include "dfs_status_params.svh"

   // Levels presented continuously by the receiver datapaths
   typedef struct packed {
      logic [5:0] narrowband_gain;
      logic [19:0] symbol_freq;
      logic [19:0] carrier_freq;
      logic phase_lock;
      logic [7:0] wideband_gain;
      logic [15:0] sweep_freq;
      logic [7:0] noise_power;
      logic [15:0] bit_errors;
      logic [23:0] signal_quality;
      logic [2:0] code_rate;
      logic pi2_resolved;
      logic pi_resolved;
      logic byte_sync;
      logic frame_sync;
      logic node_sync;
   } dfs_status_type;

   // One-cycle events from the filter and the block decoder
   typedef struct packed {
      logic symbol_tick;
      logic [7:0] inphase;
      logic [7:0] quadrature;
      logic block_done;
      logic [3:0] block_errors;
      logic uncorrectable;
   } dfs_event_type;
endpackage
